// [verilog/int_err_pkg.sv]
// shared constants, types and helpers of the internal error log bank
package int_err_pkg;

	// register offsets, byte addresses on the plain register port
	localparam logic [7:0] NEXT_ORTH_OFS = 8'hc7;
	localparam logic [7:0] NONREC_LOG_OFS = 8'hc8;
	localparam logic [7:0] REC_LOG_OFS = 8'hcc;
	localparam logic [7:0] EMASK_OFS = 8'hd0;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'he0;
	localparam logic [7:0] IRQ_MASK_OFS = 8'he4;

	// next orthogonal non-fatal register layout
	localparam int NEXT_WIDTH = 8;
	localparam int SMBUS_BIT = 1;
	localparam int TEST_PORT_BIT = 2;
	localparam int PERF_DONE_BIT = 3;
	localparam int SCRUB_SBE_BIT = 4;
	localparam logic [7:0] NEXT_W1C_BITS = 8'h1e;
	localparam logic [7:0] NEXT_RESET = 8'h00;

	// error log field positions
	localparam int LOG_COH_LSB = 0;
	localparam int LOG_BLOCK_LSB = 8;
	localparam int LOG_DIR_LSB = 13;
	localparam int LOG_SRC_LSB = 21;

	// detecting block codes
	localparam logic [2:0] BLK_PORTS_LOW = 3'h1;
	localparam logic [2:0] BLK_PORTS_HIGH = 3'h2;
	localparam logic [2:0] BLK_PORT_LAST = 3'h3;
	localparam logic [2:0] BLK_COHERENCY = 3'h4;
	localparam logic [2:0] BLK_DIRECTORY = 3'h5;
	localparam logic [2:0] BLK_IO_GATEWAY = 3'h6;

	// enable mask: writable bits, reset value, error number of scrub sbe
	localparam logic [31:0] EMASK_RW_BITS = 32'h037c2fff;
	localparam logic [31:0] EMASK_RESET = 32'h037c2fff;
	localparam logic [4:0] ERR_SCRUB_SBE = 5'h13;
	localparam logic [4:0] ERR_NUM_MAX = 5'h1a;

	// interrupt status and mask layout
	localparam int IRQ_WIDTH = 2;
	localparam int IRQ_NEXT_BIT = 0;
	localparam int IRQ_LOG_BIT = 1;
	localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h3;

	localparam int PERF_FLAGS = 4;
	localparam int TEST_FLAGS = 4;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

	typedef struct packed {
		logic scrub_sbe;
		logic [PERF_FLAGS-1:0] perf_done_flags;
		logic [TEST_FLAGS-1:0] test_port_status;
		logic smbus_error;
	} orth_event_type;

	typedef struct packed {
		logic [2:0] unaffiliated_port_unit_source;
		logic [7:0] dir_entry;
		logic [2:0] block;
		logic [6:0] coh_entry;
	} log_entry_type;

	typedef struct packed {
		logic valid;
		logic [4:0] err_num;
		log_entry_type entry;
	} log_req_type;

	// place a log entry into its 32-bit register image
	function automatic logic [31:0] log_image(input log_entry_type e);
		logic [31:0] v;
		v = 32'h0;
		v[LOG_SRC_LSB +: 3] = e.unaffiliated_port_unit_source;
		v[LOG_DIR_LSB +: 8] = e.dir_entry;
		v[LOG_BLOCK_LSB +: 3] = e.block;
		v[LOG_COH_LSB +: 7] = e.coh_entry;
		return v;
	endfunction

endpackage

// [verilog/sticky_flag_bank.sv]
// bank of write-one-to-clear flags where a set beats a clear
`timescale 1ns/1ps

module sticky_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] RESET = '0
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flags_o
);
	import int_err_pkg::*;

	typedef struct packed {
		logic [W-1:0] flags;
	} state_type;

	state_type state_r;
	state_type state_nxt;

	// an event landing in the clearing cycle must not be lost
	always_comb begin
		state_nxt = state_r;
		state_nxt.flags = (state_r.flags & ~clr_i) | set_i;
		if (rst_i) begin
			state_nxt.flags = RESET;
		end
	end

	always_ff @(posedge mclk_i) begin
		state_r <= state_nxt;
	end

	assign flags_o = state_r.flags;
endmodule

// [verilog/err_log_capture.sv]
// one error log register, loaded whole on a capture strobe
`timescale 1ns/1ps

module err_log_capture (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic capture_i,
	input wire int_err_pkg::log_entry_type entry_i,
	output int_err_pkg::log_entry_type log_o
);
	import int_err_pkg::*;

	typedef struct packed {
		log_entry_type entry;
	} state_type;

	state_type state_r;
	state_type state_nxt;

	// fields are read-only to software; only a new capture moves them
	always_comb begin
		state_nxt = state_r;
		if (capture_i) begin
			state_nxt.entry = entry_i;
		end
		if (rst_i) begin
			state_nxt.entry = '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		state_r <= state_nxt;
	end

	assign log_o = state_r.entry;
endmodule

// [verilog/internal_error_log_mask.sv]
// internal error next-log, error logs, enable mask and interrupt
`timescale 1ns/1ps

// Notes on behaviour
// - after the first orthogonal error is latched, later ones set next-log.
// - a snoop filter scrub single-bit error sets next-log bit 4.
// - next-log bit 3 is set by the OR of the perf-monitor done flags.
// - next-log bit 2 is set by the test-port stack error status bits.
// - next-log bit 1 is set by an SMBus stack error; 7:5 and 0 read zero.
// - unmasked non-recoverable internal errors load the non-recoverable log.
// - log bits 23:21 flag which I/O unit raised an unaffiliated-port error.
// - log bits 10:8 hold the code of the detecting block, 111 unused.
// - log bits 20:13 hold the directory entry, 6:0 the coherency entry.
// - the recoverable log has the same layout and never captures.
// - a mask bit of 0 enables its error, 1 suppresses; resets to ones.
// - mask bit n-1 belongs to error n; bits 31:26, 23, 17:14, 12 read zero.
module internal_error_log_mask (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire int_err_pkg::reg_req_type req_i,
	output logic [31:0] rdata_o,
	input wire logic first_orth_logged_i,
	input wire int_err_pkg::orth_event_type orth_evt_i,
	input wire int_err_pkg::log_req_type log_req_i,
	output logic [31:0] emask_o,
	output logic irq_o
);
	import int_err_pkg::*;

	// register-side state; emask is sticky, the rest follows warm reset
	typedef struct packed {
		logic [31:0] rdata;
		logic [31:0] emask;
		logic [IRQ_WIDTH-1:0] irq_mask;
	} state_type;

	state_type state_r;
	state_type state_nxt;

	logic [NEXT_WIDTH-1:0] next_set;
	logic [NEXT_WIDTH-1:0] next_clr;
	logic [NEXT_WIDTH-1:0] next_flags;
	logic [IRQ_WIDTH-1:0] irq_set;
	logic [IRQ_WIDTH-1:0] irq_clr;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic nonrec_capture;
	log_entry_type nonrec_log;
	log_entry_type rec_log;
	log_entry_type no_entry;
	logic wr_next;
	logic wr_emask;
	logic wr_irq_mask;
	logic rd_irq_status;

	// error n (1 to 26) is enabled unless its writable mask bit n-1 is one
	function automatic logic err_enabled(input logic [31:0] mask,
		input logic [4:0] num);
		logic [4:0] idx;
		idx = num - 5'h1;
		if (num == 5'h0 || num > ERR_NUM_MAX) begin
			return 1'b0;
		end
		return !(mask[idx] && EMASK_RW_BITS[idx]);
	endfunction

	// address decode of the plain register port
	assign wr_next = req_i.wr && (req_i.addr == NEXT_ORTH_OFS);
	assign wr_emask = req_i.wr && (req_i.addr == EMASK_OFS);
	assign wr_irq_mask = req_i.wr && (req_i.addr == IRQ_MASK_OFS);
	assign rd_irq_status = req_i.rd && (req_i.addr == IRQ_STATUS_OFS);

	// orthogonal events only reach next-log once the first one is held
	always_comb begin
		next_set = '0;
		if (first_orth_logged_i) begin
			next_set[SCRUB_SBE_BIT] = orth_evt_i.scrub_sbe &&
				err_enabled(state_r.emask, ERR_SCRUB_SBE);
			next_set[PERF_DONE_BIT] =
				|orth_evt_i.perf_done_flags;
			next_set[TEST_PORT_BIT] =
				|orth_evt_i.test_port_status;
			next_set[SMBUS_BIT] = orth_evt_i.smbus_error;
		end
	end

	// write-one clears only the defined bits; reserved ones never set
	assign next_clr = wr_next ?
		(req_i.wdata[NEXT_WIDTH-1:0] & NEXT_W1C_BITS) : '0;

	// sticky next-log survives warm reset, cleared only at power-on
	sticky_flag_bank #(
		.W(NEXT_WIDTH),
		.RESET(NEXT_RESET)
	) u_next_log (
		.mclk_i(mclk_i),
		.rst_i(por_i),
		.set_i(next_set & NEXT_W1C_BITS),
		.clr_i(next_clr),
		.flags_o(next_flags)
	);

	// capture only errors that the enable mask lets through
	assign nonrec_capture = log_req_i.valid &&
		err_enabled(state_r.emask, log_req_i.err_num);

	err_log_capture u_nonrec_log (
		.mclk_i(mclk_i),
		.rst_i(por_i),
		.capture_i(nonrec_capture),
		.entry_i(log_req_i.entry),
		.log_o(nonrec_log)
	);

	// no correctable datapath errors exist, so this log never loads
	assign no_entry = '0;

	err_log_capture u_rec_log (
		.mclk_i(mclk_i),
		.rst_i(por_i),
		.capture_i(1'b0),
		.entry_i(no_entry),
		.log_o(rec_log)
	);

	// interrupt events: any next-log set and any log capture
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_NEXT_BIT] = |(next_set & NEXT_W1C_BITS);
		irq_set[IRQ_LOG_BIT] = nonrec_capture;
	end

	// reading the status register clears it, a same-cycle event wins
	assign irq_clr = rd_irq_status ? {IRQ_WIDTH{1'b1}} : '0;

	sticky_flag_bank #(
		.W(IRQ_WIDTH),
		.RESET(IRQ_STATUS_RESET)
	) u_irq_status (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.flags_o(irq_status)
	);

	// next state of the register file and the registered read path
	always_comb begin
		state_nxt = state_r;
		state_nxt.rdata = 32'h0;
		if (wr_emask) begin
			// bit 25 stays writable; keeping it at one is up to software
			state_nxt.emask = req_i.wdata & EMASK_RW_BITS;
		end
		if (wr_irq_mask) begin
			state_nxt.irq_mask = req_i.wdata[IRQ_WIDTH-1:0];
		end
		if (req_i.rd) begin
			unique case (req_i.addr)
				NEXT_ORTH_OFS: begin
					state_nxt.rdata = {24'h0, next_flags};
				end
				NONREC_LOG_OFS: begin
					state_nxt.rdata = log_image(nonrec_log);
				end
				REC_LOG_OFS: begin
					state_nxt.rdata = log_image(rec_log);
				end
				EMASK_OFS: begin
					state_nxt.rdata = state_r.emask;
				end
				IRQ_STATUS_OFS: begin
					state_nxt.rdata = {30'h0, irq_status};
				end
				IRQ_MASK_OFS: begin
					state_nxt.rdata = {30'h0, state_r.irq_mask};
				end
				default: begin
					state_nxt.rdata = 32'h0; // unmapped reads zero
				end
			endcase
		end
		// warm reset touches the non-sticky part only
		if (rst_i) begin
			state_nxt.rdata = 32'h0;
			state_nxt.irq_mask = IRQ_MASK_RESET;
		end
		// power-on resets the register file, the sticky mask back to EMASK_RESET included
		if (por_i) begin
			state_nxt.rdata = 32'h0;
			state_nxt.irq_mask = IRQ_MASK_RESET;
			state_nxt.emask = EMASK_RESET;
		end
	end

	always_ff @(posedge mclk_i) begin
		state_r <= state_nxt;
	end

	// read data stand only in the cycle after the read strobe
	assign rdata_o = state_r.rdata;
	assign emask_o = state_r.emask;

	// level interrupt while any unmasked status bit is set
	assign irq_o = |(irq_status & ~state_r.irq_mask);
endmodule

// [dv/int_err_asserts.sv]
// port checker for the internal error log bank
`timescale 1ns/1ps
module int_err_asserts import int_err_pkg::*; (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire int_err_pkg::reg_req_type req_i,
	input wire logic [31:0] rdata_o,
	input wire logic first_orth_logged_i,
	input wire int_err_pkg::orth_event_type orth_evt_i,
	input wire int_err_pkg::log_req_type log_req_i,
	input wire logic [31:0] emask_o,
	input wire logic irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i || por_i);
	// decode helpers and expected log image
	wire logic rd_nxt = req_i.rd && req_i.addr == NEXT_ORTH_OFS;
	wire logic rd_log = req_i.rd && req_i.addr == NONREC_LOG_OFS;
	wire logic wr_msk = req_i.wr && req_i.addr == EMASK_OFS;
	wire log_entry_type e = log_req_i.entry;
	wire logic [31:0] img = {8'h0, e.unaffiliated_port_unit_source,
		e.dir_entry, 2'h0, e.block, 1'h0, e.coh_entry};
	next_rsv_a: assert property (rd_nxt |=> (rdata_o & 32'hffffffe1) == 0)
		else $error("next log reserved bits set");
	smbus_set_a: assert property (first_orth_logged_i &&
		orth_evt_i.smbus_error ##1 !req_i.wr ##1 rd_nxt |=> rdata_o[1])
		else $error("smbus bit not recorded");
	scrub_set_a: assert property (first_orth_logged_i &&
		orth_evt_i.scrub_sbe && !emask_o[18] ##1 !req_i.wr ##1 rd_nxt
		|=> rdata_o[4])
		else $error("scrub bit not recorded");
	log_load_a: assert property (log_req_i.valid &&
		log_req_i.err_num == 5'h9 && !emask_o[8] ##1 !log_req_i.valid
		##1 rd_log |=> rdata_o == $past(img, 3))
		else $error("log image wrong");
	rec_zero_a: assert property (req_i.rd && req_i.addr == REC_LOG_OFS
		|=> rdata_o == 0) else $error("recoverable log not zero");
	mask_rsv_a: assert property ((emask_o & ~EMASK_RW_BITS) == 0)
		else $error("mask reserved bits set");
	mask_wr_a: assert property (wr_msk
		|=> emask_o == ($past(req_i.wdata) & EMASK_RW_BITS))
		else $error("mask write lost");
	mask_keep_a: assert property (disable iff (por_i) !wr_msk
		|=> $stable(emask_o)) else $error("mask changed without write");
	mask_rd_a: assert property (req_i.rd && req_i.addr == EMASK_OFS
		|=> rdata_o == $past(emask_o)) else $error("mask read wrong");
	// main scenarios reached
	cover property (rd_log ##1 rdata_o != 0);
	cover property (irq_o);
	cover property (first_orth_logged_i && orth_evt_i.scrub_sbe);
endmodule

bind internal_error_log_mask int_err_asserts int_err_asserts_inst (
	.mclk_i(mclk_i), .rst_i(rst_i), .por_i(por_i), .req_i(req_i),
	.rdata_o(rdata_o), .first_orth_logged_i(first_orth_logged_i),
	.orth_evt_i(orth_evt_i), .log_req_i(log_req_i), .emask_o(emask_o),
	.irq_o(irq_o));

// [dv/err_source_model.sv]
// behavioural model of the hub's internal error detectors
`timescale 1ns/1ps
module err_source_model import int_err_pkg::*; (
	input wire logic mclk_i,
	output logic first_o,
	output int_err_pkg::orth_event_type evt_o,
	output int_err_pkg::log_req_type log_o
);
	// idle: no event, no capture, no first error held
	initial begin
		first_o = 1'b0;
		evt_o = '0;
		log_o = '0;
	end
	// first-error register lives here; later errors go to next-log
	task automatic hold_first(input logic v);
		@(posedge mclk_i);
		first_o <= v;
	endtask
	// one-cycle detector pulse, released after the taking edge
	task automatic fire(input orth_event_type ev);
		@(posedge mclk_i);
		evt_o <= ev;
		@(posedge mclk_i);
		evt_o <= '0;
	endtask
	task automatic report(input logic [4:0] n, input log_entry_type ent);
		@(posedge mclk_i);
		log_o <= '{1'b1, n, ent};
		@(posedge mclk_i);
		log_o <= '0;
	endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the internal error log bank
`timescale 1ns/1ps
module tb;
	import int_err_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	reg_req_type req_i = '0;
	logic [31:0] rdata_o, emask_o, img, x;
	logic irq_o, first;
	orth_event_type evt;
	orth_event_type ev [4] = '{10'h001, 10'h002, 10'h100, 10'h200};
	log_req_type logr;
	log_entry_type e;
	int mismatches = 0;
	int comparisons = 0;
	always #2.5 mclk_i = ~mclk_i;
	internal_error_log_mask internal_error_log_mask_inst (.mclk_i(mclk_i),
		.rst_i(rst_i), .por_i(por_i), .req_i(req_i), .rdata_o(rdata_o),
		.first_orth_logged_i(first), .orth_evt_i(evt), .log_req_i(logr),
		.emask_o(emask_o), .irq_o(irq_o));
	err_source_model err_source_model_inst (.mclk_i(mclk_i),
		.first_o(first), .evt_o(evt), .log_o(logr));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk_i);
		req_i.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		req_i <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk_i);
		req_i.rd <= 1'b0;
		#1 check($sformatf("reg %h", a), exp, rdata_o);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 2 us
	initial begin
		#50000;
		mismatches++;
		wrap_up();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		rd(NEXT_ORTH_OFS, 32'h0);
		rd(NONREC_LOG_OFS, 32'h0);
		rd(EMASK_OFS, 32'h037c2fff);
		wr(EMASK_OFS, 32'hffffffff);
		rd(EMASK_OFS, 32'h037c2fff);
		wr(EMASK_OFS, 32'h02000000);
		rd(EMASK_OFS, 32'h02000000);
		check("emask", 32'h02000000, emask_o);
		// nothing recorded before the first error is held elsewhere
		err_source_model_inst.fire(10'h001);
		rd(NEXT_ORTH_OFS, 32'h0);
		err_source_model_inst.hold_first(1'b1);
		x = 32'h0;
		for (int i = 0; i < 4; i++) begin
			err_source_model_inst.fire(ev[i]);
			x[i+1] = 1'b1;
			rd(NEXT_ORTH_OFS, x);
		end
		wr(NEXT_ORTH_OFS, 32'h10);
		rd(NEXT_ORTH_OFS, 32'h0e);
		wr(NEXT_ORTH_OFS, 32'h0);
		rd(NEXT_ORTH_OFS, 32'h0e);
		wr(NEXT_ORTH_OFS, 32'hff);
		rd(NEXT_ORTH_OFS, 32'h0);
		// masked scrub error is suppressed; error 9 left enabled
		wr(EMASK_OFS, 32'h037c2eff);
		err_source_model_inst.fire(10'h200);
		rd(NEXT_ORTH_OFS, 32'h0);
		for (int b = 1; b < 7; b++) begin
			e = '{3'(1 << (b % 3)), 8'(b * 37), 3'(b), 7'(b * 11)};
			img = {8'h0, e.unaffiliated_port_unit_source, e.dir_entry,
				2'h0, e.block, 1'h0, e.coh_entry};
			err_source_model_inst.report(5'h9, e);
			rd(NONREC_LOG_OFS, img);
		end
		err_source_model_inst.report(5'ha, '1);
		rd(NONREC_LOG_OFS, img);
		rd(REC_LOG_OFS, 32'h0);
		// interrupt: unmask, clear by read, raise again, mask
		wr(IRQ_MASK_OFS, 32'h0);
		#1 check("irq", 32'h1, {31'h0, irq_o});
		rd(IRQ_STATUS_OFS, 32'h3);
		#1 check("irq", 32'h0, {31'h0, irq_o});
		err_source_model_inst.fire(10'h001);
		#1 check("irq", 32'h1, {31'h0, irq_o});
		wr(IRQ_MASK_OFS, 32'h3);
		#1 check("irq", 32'h0, {31'h0, irq_o});
		rd(IRQ_MASK_OFS, 32'h3);
		// warm reset keeps sticky state
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(EMASK_OFS, 32'h037c2eff);
		rd(NONREC_LOG_OFS, img);
		rd(NEXT_ORTH_OFS, 32'h02);
		rd(IRQ_STATUS_OFS, 32'h0);
		rd(8'hf0, 32'h0);
		wrap_up();
	end
endmodule
